/* core/ivi_pkg.sv */
// Constants, types and helpers for the interrupt vector and init logic
package ivi_pkg;

   // Vector bytes
   localparam logic [7:0] CALL_OPCODE   = 8'hcd;
   localparam logic [2:0] DEFAULT_LEVEL = 3'h7;

   // First init word fields
   localparam int W1_IC4  = 0;
   localparam int W1_SINGLE_DEVICE_FLAG = 1;
   localparam int W1_ADI  = 2;
   localparam int W1_LEVEL_TRIGGER_FLAG = 3;
   localparam int W1_MARK = 4;

   // Fourth init word fields
   localparam int W4_UPM  = 0;
   localparam int W4_AUTO_END_FLAG = 1;
   localparam int W4_MS   = 2;
   localparam int W4_BUF  = 3;
   localparam int W4_SPECIAL_NESTING_FLAG = 4;

   // Operation command fields
   localparam int OC_RIS  = 0;
   localparam int OC_RR   = 1;
   localparam int OC_SEL3 = 3;
   localparam int OC_SMM  = 5;
   localparam int OC_ESMM = 6;
   localparam int OC_SL   = 6;
   localparam int OC_EOI  = 5;

   // Values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] EDGE_ARM   = 8'hff;

   // Acknowledge pulse index
   localparam logic [1:0] PULSE_FIRST  = 2'h0;
   localparam logic [1:0] PULSE_SECOND = 2'h1;
   localparam logic [1:0] PULSE_THIRD  = 2'h2;

   // Pin synchroniser: strobes idle high
   localparam int          SYNC_WIDTH = 25;
   localparam logic [24:0] SYNC_INIT  = 25'h1c01001;

   typedef enum logic [2:0] {
      ST_UNINIT    = 3'b000,
      ST_WAIT_BASE = 3'b001,
      ST_WAIT_MAP  = 3'b010,
      ST_WAIT_OPT  = 3'b011,
      ST_READY     = 3'b100
   } ivi_init_state_type;

   // Highest priority set bit; level 7 when none
   function automatic logic [2:0] ivi_top_level(input logic [7:0] v);
      logic [2:0] r;
      r = DEFAULT_LEVEL;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

endpackage

/* core/ivi_vec_if.sv */
// Interface between the controller and its vector byte formatter
`timescale 1ns/100ps
interface ivi_vec_if;
   logic       two_cycle;
   logic       interval_four;
   logic [2:0] base_low;
   logic [7:0] base_high;
   logic [2:0] level;
   logic [1:0] pulse;
   logic [7:0] vec_byte;

   modport fmt (
      input  two_cycle, interval_four, base_low, base_high, level, pulse,
      output vec_byte
   );
   modport user (
      output two_cycle, interval_four, base_low, base_high, level, pulse,
      input  vec_byte
   );
endinterface

/* core/ivi_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ivi_sync #(
   parameter int                 WIDTH = 1,
   parameter logic [WIDTH-1:0]   INIT  = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* core/ivi_vector_fmt.sv */
// Vector byte formatter for both host types
`timescale 1ns/100ps
module ivi_vector_fmt
   import ivi_pkg::*;
(
   // Format request and result
   ivi_vec_if.fmt v
);
   always_comb begin
      if (v.two_cycle) begin
         v.vec_byte = {v.base_high[7:3], v.level};
      end else begin
         case (v.pulse)
            PULSE_FIRST: begin
               v.vec_byte = CALL_OPCODE;
            end
            PULSE_SECOND: begin
               if (v.interval_four) begin
                  v.vec_byte = {v.base_low, v.level, 2'b00};
               end else begin
                  v.vec_byte = {v.base_low[2:1], v.level, 3'b000};
               end
            end
            default: begin
               v.vec_byte = v.base_high;
            end
         endcase
      end
   end
endmodule

/* core/ivi_ctrl.sv */
`timescale 1ns/100ps
module ivi_ctrl
   import ivi_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Host bus
   input  wire logic       cs_n,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic       a0,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   input  wire logic       acknowledge_pulse_n,
   output logic            int_req,
   // Requests
   input  wire logic [7:0] request_line,
   // Cascade
   input  wire logic [2:0] cascade_lines_in,
   output logic      [2:0] cascade_lines_out,
   output logic            cascade_lines_oe,
   input  wire logic       slave_program_pin_in,
   output logic            slave_program_pin_out,
   output logic            slave_program_pin_oe
);
   logic [SYNC_WIDTH-1:0] pins_raw;
   logic [SYNC_WIDTH-1:0] pins_s;
   logic                  cs_s, wr_s, rd_s, a0_s, ack_s, sp_s;
   logic [7:0]            din_s, req_s;
   logic [2:0]            cas_s;
   logic                  wr_prev_q, ack_prev_q, cs_prev_q, a0_prev_q;
   logic [7:0]            din_prev_q;
   ivi_init_state_type    state_q;
   logic                  ic4_q, single_device_flag_q, adi_q, level_trigger_flag_q;
   logic [2:0]            base_low_q;
   logic [7:0]            base_high_q, cas_map_q;
   logic                  upm_q, auto_end_flag_q, ms_q, buf_q, special_nesting_flag_q;
   logic [7:0]            req_prev_q, irr_q, imr_q, isr_q;
   logic                  smm_q, rsel_q;
   logic [1:0]            cnt_q, last_pulse;
   logic [2:0]            level_q, lvl_now;
   logic [2:0]            cas_code_q;
   logic                  cas_oe_q, int_q;
   logic [7:0]            data_q;
   logic                  data_oe_q;
   logic                  wr_take, w1_hit, ocw_take;
   logic                  ocw1, ocw2, ocw3, ready, master, owns;
   logic                  ack_low, ack_fall, ack_rise, ack_drive, rd_low;
   logic                  isr_set_now, seq_end;
   logic [7:0]            pending, inhibit, allowed, isr_clr, irr_clr;
   logic [7:0]            rd_byte;
   logic [2:0]            top_isr;

   // Pin synchronisation
   assign pins_raw = {cs_n, wr_n, rd_n, a0, data_in, acknowledge_pulse_n,
                      request_line, cascade_lines_in, slave_program_pin_in};

   ivi_sync #(
      .WIDTH (SYNC_WIDTH),
      .INIT  (SYNC_INIT)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (pins_raw),
      .q      (pins_s)
   );

   assign {cs_s, wr_s, rd_s, a0_s, din_s, ack_s, req_s, cas_s, sp_s} = pins_s;

   // Strobe history
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_prev_q  <= 1'b1;
         ack_prev_q <= 1'b1;
         cs_prev_q  <= 1'b1;
         a0_prev_q  <= 1'b0;
         din_prev_q <= BYTE_RESET;
      end else begin
         wr_prev_q  <= wr_s;
         ack_prev_q <= ack_s;
         cs_prev_q  <= cs_s;
         a0_prev_q  <= a0_s;
         din_prev_q <= din_s;
      end
   end

   // Write decode on trailing edge of write strobe
   assign wr_take  = wr_s && !wr_prev_q && !cs_prev_q;
   assign w1_hit   = wr_take && !a0_prev_q && din_prev_q[W1_MARK];
   assign ready    = (state_q == ST_READY);
   assign ocw_take = wr_take && ready && !w1_hit;
   assign ocw1     = ocw_take && a0_prev_q;
   assign ocw2     = ocw_take && !a0_prev_q && !din_prev_q[OC_SEL3];
   assign ocw3     = ocw_take && !a0_prev_q && din_prev_q[OC_SEL3];

   // Initialization sequence
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q     <= ST_UNINIT;
         ic4_q       <= 1'b0;
         single_device_flag_q      <= 1'b0;
         adi_q       <= 1'b0;
         level_trigger_flag_q      <= 1'b0;
         base_low_q  <= 3'h0;
         base_high_q <= BYTE_RESET;
         cas_map_q   <= BYTE_RESET;
         upm_q       <= 1'b0;
         auto_end_flag_q      <= 1'b0;
         ms_q        <= 1'b0;
         buf_q       <= 1'b0;
         special_nesting_flag_q      <= 1'b0;
      end else if (w1_hit) begin
         state_q    <= ST_WAIT_BASE;
         ic4_q      <= din_prev_q[W1_IC4];
         single_device_flag_q     <= din_prev_q[W1_SINGLE_DEVICE_FLAG];
         adi_q      <= din_prev_q[W1_ADI];
         level_trigger_flag_q     <= din_prev_q[W1_LEVEL_TRIGGER_FLAG];
         base_low_q <= din_prev_q[7:5];
         upm_q      <= 1'b0;
         auto_end_flag_q     <= 1'b0;
         ms_q       <= 1'b0;
         buf_q      <= 1'b0;
         special_nesting_flag_q     <= 1'b0;
      end else if (wr_take && a0_prev_q) begin
         case (state_q)
            ST_WAIT_BASE: begin
               base_high_q <= din_prev_q;
               if (!single_device_flag_q) begin
                  state_q <= ST_WAIT_MAP;
               end else if (ic4_q) begin
                  state_q <= ST_WAIT_OPT;
               end else begin
                  state_q <= ST_READY;
               end
            end
            ST_WAIT_MAP: begin
               cas_map_q <= din_prev_q;
               state_q   <= ic4_q ? ST_WAIT_OPT : ST_READY;
            end
            ST_WAIT_OPT: begin
               upm_q   <= din_prev_q[W4_UPM];
               auto_end_flag_q  <= din_prev_q[W4_AUTO_END_FLAG];
               ms_q    <= din_prev_q[W4_MS];
               buf_q   <= din_prev_q[W4_BUF];
               special_nesting_flag_q  <= din_prev_q[W4_SPECIAL_NESTING_FLAG];
               state_q <= ST_READY;
            end
            default: begin
            end
         endcase
      end
   end

   // Role selection
   assign master = buf_q ? ms_q : sp_s;

   // Request capture
   always_ff @(posedge clk) begin
      if (!resetn) begin
         req_prev_q <= EDGE_ARM;
         irr_q      <= BYTE_RESET;
      end else if (w1_hit) begin
         req_prev_q <= EDGE_ARM;
         irr_q      <= BYTE_RESET;
      end else begin
         req_prev_q <= req_s;
         if (level_trigger_flag_q) begin
            irr_q <= req_s;
         end else begin
            irr_q <= (irr_q & ~irr_clr) | (req_s & ~req_prev_q);
         end
      end
   end

   // Mask and read select
   always_ff @(posedge clk) begin
      if (!resetn) begin
         imr_q  <= BYTE_RESET;
         smm_q  <= 1'b0;
         rsel_q <= 1'b0;
      end else if (w1_hit) begin
         imr_q  <= BYTE_RESET;
         smm_q  <= 1'b0;
         rsel_q <= 1'b0;
      end else begin
         if (ocw1) begin
            imr_q <= din_prev_q;
         end
         if (ocw3 && din_prev_q[OC_ESMM]) begin
            smm_q <= din_prev_q[OC_SMM];
         end
         if (ocw3 && din_prev_q[OC_RR]) begin
            rsel_q <= din_prev_q[OC_RIS];
         end
      end
   end

   // Priority resolution, level 0 highest
   assign pending = irr_q & ~imr_q;
   assign inhibit = smm_q ? (isr_q & ~imr_q) : isr_q;
   assign top_isr = ivi_top_level(inhibit);

   always_comb begin
      allowed = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (inhibit == 8'h00 || 3'(i) < top_isr) begin
            allowed[i] = 1'b1;
         end else if (special_nesting_flag_q && master && 3'(i) == top_isr) begin
            allowed[i] = 1'b1;
         end
      end
   end

   assign lvl_now = ivi_top_level(pending & allowed);

   // Acknowledge sequence
   assign ack_low    = !ack_s && ready;
   assign ack_fall   = ack_low && ack_prev_q;
   assign ack_rise   = ack_s && !ack_prev_q && ready;
   assign last_pulse = upm_q ? PULSE_SECOND : PULSE_THIRD;
   assign seq_end    = ack_rise && (cnt_q == last_pulse);
   assign isr_set_now = ack_fall
                      && (cnt_q == (upm_q ? PULSE_SECOND : PULSE_FIRST));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q      <= PULSE_FIRST;
         level_q    <= DEFAULT_LEVEL;
         cas_code_q <= 3'h0;
         cas_oe_q   <= 1'b0;
      end else if (w1_hit || seq_end) begin
         cnt_q    <= PULSE_FIRST;
         cas_oe_q <= 1'b0;
      end else begin
         if (ack_rise) begin
            cnt_q <= cnt_q + 2'h1;
         end
         if (ack_fall && cnt_q == PULSE_FIRST) begin
            level_q    <= lvl_now;
            cas_code_q <= lvl_now;
            cas_oe_q   <= master && !single_device_flag_q && cas_map_q[lvl_now];
         end
      end
   end

   // Service register
   always_comb begin
      isr_clr = 8'h00;
      irr_clr = 8'h00;
      if (isr_set_now) begin
         irr_clr[upm_q ? level_q : lvl_now] = 1'b1;
      end
      if (seq_end && auto_end_flag_q) begin
         isr_clr[level_q] = 1'b1;
      end
      if (ocw2 && din_prev_q[OC_EOI]) begin
         if (din_prev_q[OC_SL]) begin
            isr_clr[din_prev_q[2:0]] = 1'b1;
         end else begin
            isr_clr[ivi_top_level(isr_q)] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || w1_hit) begin
         isr_q <= BYTE_RESET;
      end else begin
         isr_q <= (isr_q & ~isr_clr) | irr_clr;
      end
   end

   // Bus ownership for later vector bytes
   always_comb begin
      if (single_device_flag_q) begin
         owns = 1'b1;
      end else if (master) begin
         owns = !cas_map_q[level_q];
      end else begin
         owns = (cas_s == cas_map_q[2:0]);
      end
   end

   always_comb begin
      ack_drive = 1'b0;
      if (ack_low) begin
         if (upm_q) begin
            ack_drive = (cnt_q == PULSE_SECOND) && owns;
         end else if (cnt_q == PULSE_FIRST) begin
            ack_drive = master || single_device_flag_q;
         end else begin
            ack_drive = owns;
         end
      end
   end

   // Vector formatting
   ivi_vec_if vi ();

   assign vi.two_cycle     = upm_q;
   assign vi.interval_four = adi_q;
   assign vi.base_low      = base_low_q;
   assign vi.base_high     = base_high_q;
   assign vi.level         = level_q;
   assign vi.pulse         = cnt_q;

   ivi_vector_fmt u_fmt (
      .v (vi.fmt)
   );

   // Status read
   assign rd_low  = !rd_s && !cs_s;
   assign rd_byte = a0_s ? imr_q : (rsel_q ? isr_q : irr_q);

   // Output registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_q    <= BYTE_RESET;
         data_oe_q <= 1'b0;
         int_q     <= 1'b0;
      end else begin
         data_q    <= ack_drive ? vi.vec_byte : rd_byte;
         data_oe_q <= ack_drive || rd_low;
         int_q     <= ready && |(pending & allowed);
      end
   end

   assign data_out              = data_q;
   assign data_oe               = data_oe_q;
   assign int_req               = int_q;
   assign cascade_lines_out     = cas_code_q;
   assign cascade_lines_oe      = cas_oe_q;
   assign slave_program_pin_out = !data_oe_q;
   assign slave_program_pin_oe  = buf_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_call_opcode: assert property (
      ack_low && !upm_q && cnt_q == PULSE_FIRST && master && !single_device_flag_q
      |=> data_oe_q && data_q == CALL_OPCODE)
      else $error("call opcode missing on first pulse");

   chk_interval_four: assert property (
      ack_low && !upm_q && adi_q && cnt_q == PULSE_SECOND && owns
      |=> data_oe_q && data_q == {base_low_q, level_q, 2'b00})
      else $error("interval four byte wrong");

   chk_interval_eight: assert property (
      ack_low && !upm_q && !adi_q && cnt_q == PULSE_SECOND && owns
      |=> data_oe_q && data_q == {base_low_q[2:1], level_q, 3'b000})
      else $error("interval eight byte wrong");

   chk_high_byte: assert property (
      ack_low && !upm_q && cnt_q == PULSE_THIRD && owns
      |=> data_oe_q && data_q == base_high_q)
      else $error("upper address byte wrong");

   chk_pointer_quiet: assert property (
      ack_low && upm_q && cnt_q == PULSE_FIRST && rd_s
      |=> !data_oe_q)
      else $error("bus driven on first pointer cycle");

   chk_pointer_byte: assert property (
      ack_low && upm_q && cnt_q == PULSE_SECOND && owns
      |=> data_oe_q && data_q == {base_high_q[7:3], level_q})
      else $error("pointer byte wrong");

   chk_init_restart: assert property (
      w1_hit |=> state_q == ST_WAIT_BASE && imr_q == BYTE_RESET
      && !smm_q && !rsel_q && !auto_end_flag_q && !upm_q && !buf_q)
      else $error("first init word did not reset state");

   chk_short_init: assert property (
      wr_take && a0_prev_q && state_q == ST_WAIT_BASE && single_device_flag_q && !ic4_q
      |=> state_q == ST_READY)
      else $error("two byte init did not complete");

   chk_level_sense: assert property (
      level_trigger_flag_q && !w1_hit |=> irr_q == $past(req_s))
      else $error("level sensing not followed");

   chk_slave_select: assert property (
      ack_low && !master && !single_device_flag_q && cas_s != cas_map_q[2:0]
      && cnt_q != PULSE_FIRST && rd_s |=> !data_oe_q)
      else $error("unselected slave drove bus");

   cov_three_pulse: cover property (seq_end && !upm_q);
   cov_two_cycle:   cover property (seq_end && upm_q);
   cov_cascade_out: cover property (cas_oe_q && ack_low);
   cov_full_init:   cover property (state_q == ST_WAIT_OPT ##[1:50] ready);
endmodule

/* verif/ivi_host_model.sv */
// Host processor model: strobed writes, reads and acknowledge pulses
`timescale 1ns/100ps
module ivi_host_model (
   // Clock
   input  wire logic       clk,
   // Host bus
   output logic            cs_n,
   output logic            wr_n,
   output logic            rd_n,
   output logic            a0,
   output logic      [7:0] data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   // Acknowledge
   output logic            acknowledge_pulse_n
);
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      a0 = 1'b0;
      data_in = 8'h00;
      acknowledge_pulse_n = 1'b1;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Kind 0 write, 1 read, 2 acknowledge; strobes held 5 clocks each way
   task automatic cycle(input int k, input logic a, input logic [7:0] d,
                        output logic [8:0] v);
      idle(1);
      cs_n = (k == 2);
      a0 = a;
      data_in = d;
      wr_n = (k != 0);
      rd_n = (k != 1);
      acknowledge_pulse_n = (k != 2);
      idle(5);
      v = {data_oe, data_out};
      wr_n = 1'b1;
      rd_n = 1'b1;
      acknowledge_pulse_n = 1'b1;
      idle(5);
      cs_n = 1'b1;
      data_in = ~d;
      idle(4);
   endtask
endmodule

/* verif/test_interrupt_vector_and_init_logic.sv */
// Self-checking bench for vector bytes and init word sequencing
`timescale 1ns/100ps
module test_interrupt_vector_and_init_logic
   import ivi_pkg::*;
;
   // Clock and reset
   logic       clk                  = 1'b0;
   logic       resetn               = 1'b0;
   // Pins
   logic       cs_n;
   logic       wr_n;
   logic       rd_n;
   logic       a0;
   logic       acknowledge_pulse_n;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic       data_oe;
   logic       int_req;
   logic [7:0] request_line         = 8'h00;
   logic [2:0] cascade_lines_in     = 3'h0;
   logic [2:0] cascade_lines_out;
   logic       cascade_lines_oe;
   logic       slave_program_pin_in = 1'b1;
   logic       slave_program_pin_out;
   logic       slave_program_pin_oe;
   // Bench state
   logic [8:0] v;
   int         miscompares          = 0;
   int         n_compared           = 0;
   int         cycles               = 0;

   always #4 clk = ~clk;

   ivi_ctrl i_dut (
      .clk                   (clk),
      .resetn                (resetn),
      .cs_n                  (cs_n),
      .wr_n                  (wr_n),
      .rd_n                  (rd_n),
      .a0                    (a0),
      .data_in               (data_in),
      .data_out              (data_out),
      .data_oe               (data_oe),
      .acknowledge_pulse_n   (acknowledge_pulse_n),
      .int_req               (int_req),
      .request_line          (request_line),
      .cascade_lines_in      (cascade_lines_in),
      .cascade_lines_out     (cascade_lines_out),
      .cascade_lines_oe      (cascade_lines_oe),
      .slave_program_pin_in  (slave_program_pin_in),
      .slave_program_pin_out (slave_program_pin_out),
      .slave_program_pin_oe  (slave_program_pin_oe)
   );

   ivi_host_model i_host (
      .clk                 (clk),
      .cs_n                (cs_n),
      .wr_n                (wr_n),
      .rd_n                (rd_n),
      .a0                  (a0),
      .data_in             (data_in),
      .data_out            (data_out),
      .data_oe             (data_oe),
      .acknowledge_pulse_n (acknowledge_pulse_n)
   );

   task automatic results();
      $display("compared %0d wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   task automatic check(input string nm, input logic [8:0] seen,
                        input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic a, input logic [7:0] d);
      i_host.cycle(0, a, d, v);
   endtask

   task automatic rd(input logic a, output logic [8:0] r);
      i_host.cycle(1, a, 8'h00, r);
   endtask

   task automatic ack(output logic [8:0] r);
      i_host.cycle(2, 1'b0, 8'h00, r);
   endtask

   task automatic restart(input logic pin);
      request_line = 8'h00;
      cascade_lines_in = 3'h0;
      slave_program_pin_in = pin;
      resetn = 1'b0;
      i_host.idle(6);
      resetn = 1'b1;
      i_host.idle(2);
   endtask

   task automatic ack3(input logic [7:0] b2, input logic [7:0] b3);
      ack(v);
      check("first byte", v, {1'b1, CALL_OPCODE});
      ack(v);
      check("second byte", v, {1'b1, b2});
      ack(v);
      check("third byte", v, {1'b1, b3});
   endtask

   task automatic t_three_four();
      restart(1'b1);
      wr(1'b0, 8'hb6);
      wr(1'b1, 8'h5a);
      request_line[5] = 1'b1;
      i_host.idle(6);
      check("int_req", 9'(int_req), 9'h001);
      ack3(8'hb4, 8'h5a);
      wr(1'b0, 8'h0b);
      rd(1'b0, v);
      check("in service", v, 9'h120);
      check("pin oe", 9'(slave_program_pin_oe), 9'h000);
      $display("test three_four done");
   endtask

   task automatic t_three_eight();
      restart(1'b1);
      wr(1'b0, 8'hf2);
      wr(1'b1, 8'h00);
      request_line[3] = 1'b1;
      i_host.idle(6);
      ack3(8'hd8, 8'h00);
      $display("test three_eight done");
   endtask

   task automatic t_two_cycle();
      restart(1'b1);
      wr(1'b0, 8'h17);
      wr(1'b1, 8'hab);
      wr(1'b1, 8'h03);
      request_line[2] = 1'b1;
      i_host.idle(6);
      ack(v);
      check("first oe", 9'(v[8]), 9'h000);
      ack(v);
      check("pointer", v, 9'h1aa);
      wr(1'b0, 8'h0b);
      rd(1'b0, v);
      check("auto end", v, 9'h100);
      $display("test two_cycle done");
   endtask

   task automatic t_edges();
      restart(1'b1);
      request_line[1] = 1'b1;
      wr(1'b0, 8'h12);
      wr(1'b1, 8'h00);
      i_host.idle(6);
      check("held line", 9'(int_req), 9'h000);
      request_line[1] = 1'b0;
      i_host.idle(6);
      request_line[1] = 1'b1;
      i_host.idle(6);
      check("new edge", 9'(int_req), 9'h001);
      wr(1'b0, 8'h1a);
      wr(1'b1, 8'h00);
      i_host.idle(6);
      check("level high", 9'(int_req), 9'h001);
      request_line[1] = 1'b0;
      i_host.idle(6);
      check("level low", 9'(int_req), 9'h000);
      $display("test edges done");
   endtask

   task automatic t_mask();
      restart(1'b1);
      wr(1'b0, 8'h12);
      wr(1'b1, 8'h00);
      wr(1'b1, 8'hff);
      rd(1'b1, v);
      check("mask", v, 9'h1ff);
      wr(1'b0, 8'h0b);
      wr(1'b0, 8'h12);
      wr(1'b1, 8'h00);
      rd(1'b1, v);
      check("mask cleared", v, 9'h100);
      request_line[4] = 1'b1;
      i_host.idle(6);
      rd(1'b0, v);
      check("pending", v, 9'h110);
      $display("test mask done");
   endtask

   task automatic t_master();
      restart(1'b1);
      wr(1'b0, 8'h11);
      wr(1'b1, 8'h00);
      wr(1'b1, 8'h08);
      wr(1'b1, 8'h14);
      request_line[3] = 1'b1;
      i_host.idle(6);
      ack(v);
      check("master call", v, {1'b1, CALL_OPCODE});
      check("cascade", {5'h00, cascade_lines_oe, cascade_lines_out},
            9'h00b);
      ack(v);
      check("master second oe", 9'(v[8]), 9'h000);
      ack(v);
      check("master third oe", 9'(v[8]), 9'h000);
      check("cas released", 9'(cascade_lines_oe), 9'h000);
      request_line[3] = 1'b0;
      i_host.idle(6);
      request_line[3] = 1'b1;
      i_host.idle(6);
      check("nested again", 9'(int_req), 9'h001);
      $display("test master done");
   endtask

   task automatic t_slave();
      restart(1'b1);
      wr(1'b0, 8'h11);
      wr(1'b1, 8'h40);
      wr(1'b1, 8'h46);
      wr(1'b1, 8'h08);
      check("pin oe", 9'(slave_program_pin_oe), 9'h001);
      cascade_lines_in = 3'h6;
      request_line[6] = 1'b1;
      i_host.idle(6);
      ack(v);
      check("slave first oe", 9'(v[8]), 9'h000);
      fork
         ack(v);
         begin
            i_host.idle(4);
            check("en", 9'(slave_program_pin_out), 9'h000);
         end
      join
      check("slave second", v, 9'h130);
      ack(v);
      check("slave third", v, 9'h140);
      check("en idle", 9'(slave_program_pin_out), 9'h001);
      cascade_lines_in = 3'h5;
      request_line[6] = 1'b0;
      i_host.idle(6);
      request_line[6] = 1'b1;
      i_host.idle(6);
      ack(v);
      ack(v);
      check("other slave oe", 9'(v[8]), 9'h000);
      ack(v);
      check("other slave third", 9'(v[8]), 9'h000);
      wr(1'b0, 8'h12);
      wr(1'b1, 8'h00);
      check("oe cleared", 9'(slave_program_pin_oe), 9'h000);
      $display("test slave done");
   endtask

   task automatic t_pin_slave();
      restart(1'b0);
      wr(1'b0, 8'h10);
      wr(1'b1, 8'h60);
      wr(1'b1, 8'h02);
      cascade_lines_in = 3'h2;
      request_line[2] = 1'b1;
      i_host.idle(6);
      ack(v);
      check("strap first oe", 9'(v[8]), 9'h000);
      check("strap cas oe", 9'(cascade_lines_oe), 9'h000);
      ack(v);
      check("strap second", v, 9'h110);
      ack(v);
      check("strap third", v, 9'h160);
      $display("test pin_slave done");
   endtask

   initial begin
      t_three_four();
      t_three_eight();
      t_two_cycle();
      t_edges();
      t_mask();
      t_master();
      t_slave();
      t_pin_slave();
      results();
   end
endmodule
